//--- hw/wdw_top.sv
// watchdog timer with halt wake-up control and reset flags
`timescale 1ns/1ns
`default_nettype none
`include "wdw_defs.svh"
module wdw_top (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [31:0]           awaddr,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  output logic [1:0]                 bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  input  wire logic [31:0]           araddr,
  input  wire logic                  arvalid,
  output logic                       arready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  output logic                       rvalid,
  input  wire logic                  rready,
  input  wire logic                  low_speed_internal_osc,
  input  wire logic                  ext_reset_pin_n,
  input  wire logic [`WDW_PA_W-1:0]  port_a_pins,
  input  wire logic                  clear_watchdog_instruction,
  input  wire logic                  halt_instruction,
  input  wire logic                  lvr_event,
  input  wire logic [`WDW_IRQ_W-1:0] irq_request,
  input  wire logic [`WDW_IRQ_W-1:0] irq_enable,
  input  wire logic                  stack_full,
  output logic                       device_reset,
  output logic                       pc_sp_reset,
  output logic                       wake,
  output logic                       resume_after_halt,
  output logic                       irq_entry,
  output logic                       halted,
  output logic                       idle_sysclk_keep,
  output logic                       timeout_status_flag,
  output logic                       power_down_flag
);
  import wdw_pkg::*;

  wdw_wreq_t                 wreq;
  wdw_rreq_t                 rreq;
  logic [31:0]               rd_data;
  wdw_state_t                state_ff;
  logic                      low_speed_internal_osc_s1_ff, low_speed_internal_osc_s2_ff, low_speed_internal_osc_s3_ff;
  logic                      rpin_s1_ff, rpin_s2_ff;
  logic [`WDW_PA_W-1:0]      pa_s1_ff, pa_s2_ff, pa_s3_ff;
  logic [7:0]                ctrl_ff;
  logic [`WDW_PA_W-1:0]      port_a_wake_enable_ff;
  logic [`WDW_IRQ_W-1:0]     irq_pre_ff;
  logic [`WDW_CNT_W-1:0]     cnt_ff;
  logic [1:0]                key_cnt_ff;
  logic                      rsv_ff, low_voltage_reset_flag_ff, key_reset_flag_ff;
  logic                      sysclk_keep_ff, to_ff, pdf_ff, halted_ff;
  logic                      dev_rst_ff, pcsp_ff, wake_ff, resume_ff;
  logic                      irq_entry_ff;
  logic                      tick, ext_low, wdt_on, key_bad, key_fire;
  logic                      ovf, in_halt, pa_any, irq_any, irq_service;
  logic                      wr_ctrl, wr_flags, wr_wake, quiet;
  logic [`WDW_IRQ_W-1:0]     irq_new;

  wdw_axil_slave u_slave (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .wreq    (wreq),
    .rreq    (rreq),
    .rd_data (rd_data)
  );

  // pin synchronisers, third stage only for edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_speed_internal_osc_s1_ff <= 1'b0;
      low_speed_internal_osc_s2_ff <= 1'b0;
      low_speed_internal_osc_s3_ff <= 1'b0;
      rpin_s1_ff <= 1'b1;
      rpin_s2_ff <= 1'b1;
      pa_s1_ff   <= {`WDW_PA_W{1'b1}};
      pa_s2_ff   <= {`WDW_PA_W{1'b1}};
      pa_s3_ff   <= {`WDW_PA_W{1'b1}};
    end else begin
      low_speed_internal_osc_s1_ff <= low_speed_internal_osc;
      low_speed_internal_osc_s2_ff <= low_speed_internal_osc_s1_ff;
      low_speed_internal_osc_s3_ff <= low_speed_internal_osc_s2_ff;
      rpin_s1_ff <= ext_reset_pin_n;
      rpin_s2_ff <= rpin_s1_ff;
      pa_s1_ff   <= port_a_pins;
      pa_s2_ff   <= pa_s1_ff;
      pa_s3_ff   <= pa_s2_ff;
    end
  end

  // decoded events
  assign tick     = low_speed_internal_osc_s2_ff && !low_speed_internal_osc_s3_ff;
  assign ext_low  = !rpin_s2_ff;
  assign in_halt  = (state_ff == wdw_st_halt);
  assign wdt_on   = (ctrl_ff[`WDW_KEY_MSB:`WDW_KEY_LSB] == `WDW_KEY_ON);
  assign key_bad  = !wdt_on &&
                    (ctrl_ff[`WDW_KEY_MSB:`WDW_KEY_LSB] != `WDW_KEY_OFF);
  assign key_fire = key_bad && tick &&
                    (key_cnt_ff == `WDW_KEY_TICKS - 2'h1);
  assign quiet    = !ext_low && !clear_watchdog_instruction &&
                    !halt_instruction && !key_fire;
  assign ovf      = wdt_on && tick && quiet &&
                    (cnt_ff == wdw_limit(ctrl_ff[`WDW_SEL_MSB:0]));
  assign pa_any   = |(pa_s3_ff & ~pa_s2_ff & port_a_wake_enable_ff);
  assign irq_new  = irq_request & ~irq_pre_ff;
  assign irq_any  = |irq_new;
  assign irq_service = (|(irq_new & irq_enable)) && !stack_full;

  // register write strobes, low byte lane only
  assign wr_ctrl  = wreq.en && wreq.strb[0] && wreq.addr == `WDW_OFF_CTRL;
  assign wr_flags = wreq.en && wreq.strb[0] && wreq.addr == `WDW_OFF_FLAGS;
  assign wr_wake  = wreq.en && wreq.strb[0] && wreq.addr == `WDW_OFF_WAKE;

  // control register, reloaded by any full device reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= `WDW_CTRL_POR;
    end else if (ext_low || key_fire || (ovf && !in_halt)) begin
      ctrl_ff <= `WDW_CTRL_POR;
    end else if (wr_ctrl) begin
      ctrl_ff <= wreq.data[7:0];
    end
  end

  // slow ticks seen while the key holds an illegal value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_cnt_ff <= 2'h0;
    end else if (!key_bad) begin
      key_cnt_ff <= 2'h0;
    end else if (tick) begin
      key_cnt_ff <= key_cnt_ff + 2'h1;
    end
  end

  // watchdog counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= {`WDW_CNT_W{1'b0}};
    end else if (!quiet || ovf || !wdt_on) begin
      cnt_ff <= {`WDW_CNT_W{1'b0}};
    end else if (tick) begin
      cnt_ff <= cnt_ff + {{(`WDW_CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // halt state and snapshot of pending requests
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff   <= wdw_st_run;
      halted_ff  <= 1'b0;
      irq_pre_ff <= {`WDW_IRQ_W{1'b0}};
    end else begin
      unique case (state_ff)
        wdw_st_run: begin
          if (halt_instruction && !ext_low) begin
            state_ff   <= wdw_st_halt;
            halted_ff  <= 1'b1;
            irq_pre_ff <= irq_request;
          end
        end
        wdw_st_halt: begin
          if (ext_low || ovf || pa_any || irq_any) begin
            state_ff  <= wdw_st_run;
            halted_ff <= 1'b0;
          end
        end
      endcase
    end
  end

  // reset and wake outputs, one cycle pulses, except device_reset, which stays high while the reset pin is low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dev_rst_ff   <= 1'b0;
      pcsp_ff      <= 1'b0;
      wake_ff      <= 1'b0;
      resume_ff    <= 1'b0;
      irq_entry_ff <= 1'b0;
    end else begin
      dev_rst_ff   <= ext_low || key_fire || (ovf && !in_halt);
      pcsp_ff      <= ovf && in_halt && !ext_low;
      wake_ff      <= in_halt && (ext_low || ovf || pa_any || irq_any);
      resume_ff    <= in_halt && !ext_low && !ovf &&
                      (pa_any || (irq_any && !irq_service));
      irq_entry_ff <= in_halt && !ext_low && !ovf && !pa_any &&
                      irq_service;
    end
  end

  // timeout and power-down status, set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      to_ff  <= 1'b0;
      pdf_ff <= 1'b0;
    end else begin
      if (ovf) begin
        to_ff <= 1'b1;
      end else if (clear_watchdog_instruction || halt_instruction) begin
        to_ff <= 1'b0;
      end
      if (halt_instruction && !in_halt) begin
        pdf_ff <= 1'b1;
      end else if (clear_watchdog_instruction) begin
        pdf_ff <= 1'b0;
      end
    end
  end

  // shared flag register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sysclk_keep_ff    <= 1'(`WDW_FLAGS_POR >> `WDW_FLG_SYSCLK);
      rsv_ff            <= 1'b0;
      low_voltage_reset_flag_ff           <= 1'b0;
      key_reset_flag_ff <= 1'b0;
    end else begin
      if (wr_flags) begin
        sysclk_keep_ff <= wreq.data[`WDW_FLG_SYSCLK];
        rsv_ff         <= wreq.data[`WDW_FLG_RSV];
      end
      if (lvr_event) begin
        low_voltage_reset_flag_ff <= 1'b1;
      end else if (wr_flags && !wreq.data[`WDW_FLG_LVR]) begin
        low_voltage_reset_flag_ff <= 1'b0;
      end
      if (key_fire) begin
        key_reset_flag_ff <= 1'b1;
      end else if (wr_flags && !wreq.data[`WDW_FLG_KEY]) begin
        key_reset_flag_ff <= 1'b0;
      end
    end
  end

  // port a wake enables
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_a_wake_enable_ff <= `WDW_WAKE_POR;
    end else if (wr_wake) begin
      port_a_wake_enable_ff <= wreq.data[`WDW_PA_W-1:0];
    end
  end

  // read data mux, unused bits zero
  always_comb begin
    rd_data = 32'h0000_0000;
    if (rreq.addr == `WDW_OFF_CTRL) begin
      rd_data[7:0] = ctrl_ff;
    end else if (rreq.addr == `WDW_OFF_FLAGS) begin
      rd_data[`WDW_FLG_SYSCLK] = sysclk_keep_ff;
      rd_data[`WDW_FLG_RSV]    = rsv_ff;
      rd_data[`WDW_FLG_LVR]    = low_voltage_reset_flag_ff;
      rd_data[`WDW_FLG_KEY]    = key_reset_flag_ff;
    end else if (rreq.addr == `WDW_OFF_WAKE) begin
      rd_data[`WDW_PA_W-1:0] = port_a_wake_enable_ff;
    end else if (rreq.addr == `WDW_OFF_STAT) begin
      rd_data[`WDW_STAT_TO]   = to_ff;
      rd_data[`WDW_STAT_PDF]  = pdf_ff;
      rd_data[`WDW_STAT_HALT] = halted_ff;
    end
  end

  assign device_reset        = dev_rst_ff;
  assign pc_sp_reset         = pcsp_ff;
  assign wake                = wake_ff;
  assign resume_after_halt   = resume_ff;
  assign irq_entry           = irq_entry_ff;
  assign halted              = halted_ff;
  assign idle_sysclk_keep    = sysclk_keep_ff;
  assign timeout_status_flag = to_ff;
  assign power_down_flag     = pdf_ff;

  // helper: slow ticks since the key went illegal
  logic [2:0] bad_ticks_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn || !key_bad) begin
      bad_ticks_ff <= 3'h0;
    end else if (tick && bad_ticks_ff != 3'h7) begin
      bad_ticks_ff <= bad_ticks_ff + 3'h1;
    end
  end

  property p_key_delay;
    @(posedge aclk) disable iff (!aresetn)
    key_bad && tick && !device_reset |-> ##1
      (device_reset == (bad_ticks_ff == 3'h3));
  endproperty
  a_key_delay: assert property (p_key_delay)
    else $error("illegal key reset not on third slow tick");

  property p_key_flag;
    @(posedge aclk) disable iff (!aresetn)
    key_fire |=> device_reset && key_reset_flag_ff ##1 wdt_on;
  endproperty
  a_key_flag: assert property (p_key_flag)
    else $error("key reset did not flag and restore control");

  property p_wrf_no_set;
    @(posedge aclk) disable iff (!aresetn)
    !key_reset_flag_ff && !key_fire |=> !key_reset_flag_ff;
  endproperty
  a_wrf_no_set: assert property (p_wrf_no_set)
    else $error("key reset flag set without illegal key");

  property p_lvr_no_set;
    @(posedge aclk) disable iff (!aresetn)
    !low_voltage_reset_flag_ff && !lvr_event |=> !low_voltage_reset_flag_ff;
  endproperty
  a_lvr_no_set: assert property (p_lvr_no_set)
    else $error("low voltage flag set by software");

  property p_ovf_run;
    @(posedge aclk) disable iff (!aresetn)
    ovf && !halted_ff |=> device_reset && timeout_status_flag &&
                          !pc_sp_reset;
  endproperty
  a_ovf_run: assert property (p_ovf_run)
    else $error("running overflow did not reset device");

  property p_ovf_halt;
    @(posedge aclk) disable iff (!aresetn)
    ovf && halted_ff && !ext_low |=> pc_sp_reset && !device_reset &&
                                     timeout_status_flag && !halted_ff;
  endproperty
  a_ovf_halt: assert property (p_ovf_halt)
    else $error("halted overflow gave wrong reset");

  property p_clear;
    @(posedge aclk) disable iff (!aresetn)
    clear_watchdog_instruction |=> cnt_ff == '0 && !power_down_flag;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear instruction did not restart count");

  property p_halt_entry;
    @(posedge aclk) disable iff (!aresetn)
    halt_instruction && !halted_ff && !ext_low |=> halted_ff &&
      power_down_flag && !timeout_status_flag && cnt_ff == '0;
  endproperty
  a_halt_entry: assert property (p_halt_entry)
    else $error("halt entry state wrong");

  property p_pa_wake;
    @(posedge aclk) disable iff (!aresetn)
    halted_ff && pa_any && !ext_low && !ovf |=> resume_after_halt &&
                                               wake && !irq_entry;
  endproperty
  a_pa_wake: assert property (p_pa_wake)
    else $error("port a wake did not resume");

  property p_old_irq;
    @(posedge aclk) disable iff (!aresetn)
    halted_ff && irq_request == irq_pre_ff && !pa_any && !ext_low &&
    !ovf |=> !wake && halted_ff;
  endproperty
  a_old_irq: assert property (p_old_irq)
    else $error("stale request woke the device");
endmodule
`default_nettype wire

//--- shared/wdw_defs.svh
// constants for the watchdog and wake-up block
`ifndef WDW_DEFS_SVH
`define WDW_DEFS_SVH
`define WDW_OFF_CTRL     32'h0000_0000
`define WDW_OFF_FLAGS    32'h0000_0004
`define WDW_OFF_WAKE     32'h0000_0008
`define WDW_OFF_STAT     32'h0000_000C
`define WDW_CTRL_POR     8'h53
`define WDW_FLAGS_POR    8'h00
`define WDW_WAKE_POR     8'h00
`define WDW_KEY_OFF      5'h15
`define WDW_KEY_ON       5'h0A
`define WDW_KEY_MSB      7
`define WDW_KEY_LSB      3
`define WDW_SEL_MSB      2
`define WDW_FLG_SYSCLK   7
`define WDW_FLG_RSV      3
`define WDW_FLG_LVR      2
`define WDW_FLG_KEY      0
`define WDW_STAT_TO      0
`define WDW_STAT_PDF     1
`define WDW_STAT_HALT    2
`define WDW_POW_BASE     4'h8
`define WDW_CNT_W        15
`define WDW_KEY_TICKS    2'h3
`define WDW_PA_W         8
`define WDW_IRQ_W        8
`define WDW_RESP_OKAY    2'h0
`define WDW_RESP_SLVERR  2'h2
`endif

//--- shared/wdw_pkg.sv
// types and helper functions for the watchdog and wake-up block
`default_nettype none
`include "wdw_defs.svh"
package wdw_pkg;
  typedef enum logic [0:0] {
    wdw_st_run  = 1'b0,
    wdw_st_halt = 1'b1
  } wdw_state_t;

  typedef struct packed {
    logic        en;
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } wdw_wreq_t;

  typedef struct packed {
    logic        en;
    logic [31:0] addr;
  } wdw_rreq_t;

  // true for any mapped register word
  function automatic logic wdw_addr_hit(input logic [31:0] a);
    return (a == `WDW_OFF_CTRL) || (a == `WDW_OFF_FLAGS) ||
           (a == `WDW_OFF_WAKE) || (a == `WDW_OFF_STAT);
  endfunction

  // last count before overflow for a period select code
  function automatic logic [`WDW_CNT_W-1:0] wdw_limit(input logic [2:0] sel);
    logic [`WDW_CNT_W:0] one;
    one = {{`WDW_CNT_W{1'b0}}, 1'b1} << ({1'b0, sel} + `WDW_POW_BASE);
    return one[`WDW_CNT_W-1:0] - {{(`WDW_CNT_W-1){1'b0}}, 1'b1};
  endfunction
endpackage
`default_nettype wire

//--- hw/wdw_axil_slave.sv
// axi4-lite slave front end for the watchdog registers
`timescale 1ns/1ns
`default_nettype none
`include "wdw_defs.svh"
module wdw_axil_slave (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [31:0]       awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [31:0]       araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  output wdw_pkg::wdw_wreq_t     wreq,
  output wdw_pkg::wdw_rreq_t     rreq,
  input  wire logic [31:0]       rd_data
);
  import wdw_pkg::*;

  logic        awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [31:0] aw_addr_ff, w_data_ff, rdata_ff;
  logic [3:0]  w_strb_ff;
  logic [1:0]  bresp_ff, rresp_ff;
  logic        do_write;

  // both halves held and no response outstanding
  assign do_write = !awready_ff && !wready_ff && !bvalid_ff;

  // write address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b1;
      aw_addr_ff <= 32'h0000_0000;
    end else if (awvalid && awready_ff) begin
      awready_ff <= 1'b0;
      aw_addr_ff <= awaddr;
    end else if (bvalid_ff && bready) begin
      awready_ff <= 1'b1;
    end
  end

  // write data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_ff <= 1'b1;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
    end else if (wvalid && wready_ff) begin
      wready_ff <= 1'b0;
      w_data_ff <= wdata;
      w_strb_ff <= wstrb;
    end else if (bvalid_ff && bready) begin
      wready_ff <= 1'b1;
    end
  end

  // write response, error for unmapped words
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= `WDW_RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= wdw_addr_hit(aw_addr_ff) ? `WDW_RESP_OKAY
                                            : `WDW_RESP_SLVERR;
    end else if (bvalid_ff && bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // read channel, data registered one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= `WDW_RESP_OKAY;
    end else if (arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rdata_ff   <= wdw_addr_hit(araddr) ? rd_data : 32'h0000_0000;
      rresp_ff   <= wdw_addr_hit(araddr) ? `WDW_RESP_OKAY
                                         : `WDW_RESP_SLVERR;
    end else if (rvalid_ff && rready) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
    end
  end

  // register-side strobes
  assign wreq.en   = do_write && wdw_addr_hit(aw_addr_ff);
  assign wreq.addr = aw_addr_ff;
  assign wreq.data = w_data_ff;
  assign wreq.strb = w_strb_ff;
  assign rreq.en   = arvalid && arready_ff;
  assign rreq.addr = araddr;

  assign awready = awready_ff;
  assign wready  = wready_ff;
  assign bvalid  = bvalid_ff;
  assign bresp   = bresp_ff;
  assign arready = arready_ff;
  assign rvalid  = rvalid_ff;
  assign rdata   = rdata_ff;
  assign rresp   = rresp_ff;
endmodule
`default_nettype wire

//--- verif/test_watchdog_with_wakeup.sv
// self-checking bench for the watchdog and wake-up block
`timescale 1ns/1ns
`default_nettype none
`include "wdw_defs.svh"
module test_watchdog_with_wakeup;
  logic        aclk = 1'b0, aresetn = 1'b0, low_speed_internal_osc = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, ext_reset_pin_n = 1'b1;
  logic        clear_watchdog_instruction = 1'b0, halt_instruction = 1'b0;
  logic        lvr_event = 1'b0, stack_full = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, device_reset;
  logic        pc_sp_reset, wake, resume_after_halt, irq_entry, halted;
  logic        idle_sysclk_keep, timeout_status_flag, power_down_flag;
  logic [1:0]  bresp, rresp;
  logic [3:0]  wstrb = 4'hF;
  logic [7:0]  port_a_pins = 8'hFF, irq_request = 8'h00, irq_enable = 8'h00;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  int          mismatches = 0, comparisons = 0;
  int          n_rst = 0, n_pc = 0, n_wake = 0, n_res = 0, n_irq = 0;

  wdw_top DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .low_speed_internal_osc,
    .ext_reset_pin_n, .port_a_pins, .clear_watchdog_instruction,
    .halt_instruction, .lvr_event, .irq_request, .irq_enable, .stack_full,
    .device_reset, .pc_sp_reset, .wake, .resume_after_halt, .irq_entry,
    .halted, .idle_sysclk_keep, .timeout_status_flag, .power_down_flag);

  // 125 MHz clock
  always #4 aclk = ~aclk;

  // pulse counters, updated late so tasks read a stable count
  always @(posedge aclk) begin
    n_rst <= n_rst + int'(device_reset);
    n_pc <= n_pc + int'(pc_sp_reset);
    n_wake <= n_wake + int'(wake);
    n_res <= n_res + int'(resume_after_halt);
    n_irq <= n_irq + int'(irq_entry);
  end

  task automatic chk(input string nm, input logic [31:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      mismatches++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // slow oscillator periods of eight fast cycles each
  task automatic tick(input int n);
    repeat (n) begin
      low_speed_internal_osc <= 1'b1;
      cyc(4);
      low_speed_internal_osc <= 1'b0;
      cyc(4);
    end
  endtask

  // axi4-lite write, response code compared
  task automatic wr(input logic [31:0] a, d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    // bready stays up, so a following call never drives it twice at once
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask

  // axi4-lite read, data and response compared
  task automatic rd(input string nm, input logic [31:0] a, exp,
                    input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    // rready stays up, so a following call never drives it twice at once
    chk(nm, exp, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask

  task automatic do_halt;
    halt_instruction <= 1'b1;
    cyc(1);
    halt_instruction <= 1'b0;
    cyc(2);
  endtask

  task automatic t_regs;
    rd("ctrl", `WDW_OFF_CTRL, 32'h53, 2'h0);
    rd("flags", `WDW_OFF_FLAGS, 32'h0, 2'h0);
    rd("unmapped", 32'h10, 32'h0, 2'h2);
    wr(32'h14, 32'hFF, 2'h2);
    lvr_event <= 1'b1;
    cyc(1);
    lvr_event <= 1'b0;
    wr(`WDW_OFF_FLAGS, 32'h05, 2'h0);
    rd("flags", `WDW_OFF_FLAGS, 32'h04, 2'h0);
    wr(`WDW_OFF_FLAGS, 32'h88, 2'h0);
    rd("flags", `WDW_OFF_FLAGS, 32'h88, 2'h0);
    chk("keep", 32'h1, idle_sysclk_keep);
  endtask

  task automatic t_overflow;
    int r;
    wr(`WDW_OFF_CTRL, 32'h50, 2'h0);
    tick(200);
    for (int s = 0; s < 2; s++) begin
      r = n_rst;
      if (s > 0) wr(`WDW_OFF_CTRL, 32'h50 | s, 2'h0);
      // clear restarts the count and drops the timeout flag
      clear_watchdog_instruction <= 1'b1;
      cyc(1);
      clear_watchdog_instruction <= 1'b0;
      tick((256 << s) - 1);
      chk("early reset", r, n_rst);
      chk("early timeout", 32'h0, timeout_status_flag);
      tick(1);
      chk("overflow reset", r + 1, n_rst);
      chk("timeout", 32'h1, timeout_status_flag);
      rd("ctrl", `WDW_OFF_CTRL, 32'h53, 2'h0);
    end
  endtask

  task automatic t_halt_overflow;
    int r;
    int p;
    r = n_rst;
    p = n_pc;
    wr(`WDW_OFF_CTRL, 32'h50, 2'h0);
    do_halt();
    chk("halted", 32'h1, halted);
    chk("pdf", 32'h1, power_down_flag);
    chk("timeout", 32'h0, timeout_status_flag);
    tick(256);
    chk("partial reset", p + 1, n_pc);
    chk("full reset", r, n_rst);
    chk("timeout", 32'h1, timeout_status_flag);
    rd("ctrl", `WDW_OFF_CTRL, 32'h50, 2'h0);
    clear_watchdog_instruction <= 1'b1;
    cyc(1);
    clear_watchdog_instruction <= 1'b0;
    cyc(2);
    chk("pdf", 32'h0, power_down_flag);
  endtask

  task automatic t_key;
    int r;
    r = n_rst;
    wr(`WDW_OFF_CTRL, 32'hA8, 2'h0);
    tick(260);
    chk("disabled", r, n_rst);
    wr(`WDW_OFF_CTRL, 32'h03, 2'h0);
    tick(2);
    chk("key early", r, n_rst);
    tick(1);
    chk("key reset", r + 1, n_rst);
    rd("flags", `WDW_OFF_FLAGS, 32'h89, 2'h0);
    rd("ctrl", `WDW_OFF_CTRL, 32'h53, 2'h0);
    wr(`WDW_OFF_FLAGS, 32'h00, 2'h0);
    rd("flags", `WDW_OFF_FLAGS, 32'h00, 2'h0);
  endtask

  task automatic t_wake;
    int w;
    int q;
    int i;
    w = n_wake;
    q = n_res;
    i = n_irq;
    wr(`WDW_OFF_WAKE, 32'h01, 2'h0);
    do_halt();
    port_a_pins <= 8'hFD;
    cyc(8);
    chk("masked pin", w, n_wake);
    port_a_pins <= 8'hFC;
    cyc(8);
    chk("pin wake", w + 1, n_wake);
    chk("pin resume", q + 1, n_res);
    port_a_pins <= 8'hFF;
    irq_request <= 8'h04;
    irq_enable <= 8'h08;
    do_halt();
    cyc(8);
    chk("old request", w + 1, n_wake);
    irq_request <= 8'h0C;
    cyc(8);
    chk("irq entry", i + 1, n_irq);
    irq_request <= 8'h00;
    do_halt();
    irq_request <= 8'h10;
    cyc(8);
    chk("irq resume", q + 2, n_res);
    irq_request <= 8'h00;
    stack_full <= 1'b1;
    do_halt();
    irq_request <= 8'h08;
    cyc(8);
    chk("stack full", q + 3, n_res);
    chk("no entry", i + 1, n_irq);
  endtask

  task automatic t_pin;
    int r;
    r = n_rst;
    do_halt();
    ext_reset_pin_n <= 1'b0;
    cyc(8);
    chk("pin reset", 32'h1, n_rst > r);
    chk("halted", 32'h0, halted);
    ext_reset_pin_n <= 1'b1;
    cyc(4);
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (40000) @(posedge aclk);
    mismatches++;
    finish_test();
  end

  // main sequence
  initial begin
    cyc(5);
    aresetn <= 1'b1;
    cyc(1);
    t_regs();
    t_overflow();
    t_halt_overflow();
    t_key();
    t_wake();
    t_pin();
    finish_test();
  end
endmodule
`default_nettype wire
